/* rtl/ssp_pkg.sv */
package ssp_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BUF = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ISR = 8'h0c;
  localparam logic [7:0] ADDR_IMR = 8'h10;

  // Control register fields
  localparam int CTRL_OV = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_CKP = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Status and interrupt fields
  localparam int STAT_BF = 0;
  localparam int STAT_BUSY = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OV = 1;

  // Mode select codes
  localparam logic [3:0] MODE_M4 = 4'h0;
  localparam logic [3:0] MODE_M16 = 4'h1;
  localparam logic [3:0] MODE_M64 = 4'h2;
  localparam logic [3:0] MODE_SL_SS = 4'h4;
  localparam logic [3:0] MODE_SL = 4'h5;
  localparam logic [3:0] MODE_I2C7 = 4'h6;
  localparam logic [3:0] MODE_I2C10 = 4'h7;
  localparam logic [3:0] MODE_I2C_FW = 4'hb;
  localparam logic [3:0] MODE_I2C7_SP = 4'he;
  localparam logic [3:0] MODE_I2C10_SP = 4'hf;

  // Half serial-clock periods in aclk cycles for divide by 4, 16, 64
  localparam logic [5:0] HALF_4 = 6'h02;
  localparam logic [5:0] HALF_16 = 6'h08;
  localparam logic [5:0] HALF_64 = 6'h20;
  localparam logic [3:0] LAST_BIT = 4'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin group: 0 clock, 1 data out or SDA, 2 data in
  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } ssp_pins_t;

  typedef enum logic {PH_LEAD, PH_TRAIL} ssp_phase_t;

  function automatic logic ssp_is_master(input logic [3:0] m);
    return (m == MODE_M4) || (m == MODE_M16) || (m == MODE_M64);
  endfunction

  function automatic logic ssp_is_slave(input logic [3:0] m);
    return (m == MODE_SL_SS) || (m == MODE_SL);
  endfunction

  function automatic logic ssp_is_i2c(input logic [3:0] m);
    return (m == MODE_I2C7) || (m == MODE_I2C10) || (m == MODE_I2C_FW) ||
      (m == MODE_I2C7_SP) || (m == MODE_I2C10_SP);
  endfunction

endpackage

/* rtl/ssp_baud.sv */
`timescale 1ns/1ps
module ssp_baud import ssp_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Half-period strobe
  output logic tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } ssp_baud_st_t;

  ssp_baud_st_t s;
  ssp_baud_st_t next_s;
  logic [5:0] half;

  always_comb begin
    next_s = s;
    unique case (sel)
      MODE_M16[1:0]: half = HALF_16;
      MODE_M64[1:0]: half = HALF_64;
      default: half = HALF_4;
    endcase
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 6'h00;
    end else if (s.cnt == half - 6'h01) begin
      next_s.cnt = 6'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_div4;
    (run && sel == 2'h0 && tick) ##1 (run && sel == 2'h0) |-> !tick ##1 tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 tick spacing wrong");

endmodule // ssp_baud

/* rtl/ssp_top.sv */
`timescale 1ns/1ps
module ssp_top import ssp_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pins
  input wire ssp_pins_t gpio,
  input wire logic [2:0] pin_in,
  input wire logic ss_n,
  output ssp_pins_t pins,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic bf;
    logic busy;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    ssp_phase_t phase;
    logic sck_q;
    logic sck;
    logic serial_out_pin;
    logic [1:0] isr;
    logic [1:0] imr;
    logic irq;
    ssp_pins_t pins;
    logic aw_v;
    logic [7:0] awaddr;
    logic w_v;
    logic [31:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssp_state_t;

  ssp_state_t s;
  ssp_state_t next_s;

  logic tick;
  logic en;
  logic clock_polarity_bit;
  logic [3:0] mode;
  logic master;
  logic slave;
  logic i2c;
  logic wr_go;
  logic rd_go;
  logic sck_edge;
  logic done_evt;
  logic ovf_evt;
  logic [7:0] rx_byte;

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_BUF) || (a == ADDR_STAT) ||
      (a == ADDR_ISR) || (a == ADDR_IMR);
  endfunction

  assign en = s.ctrl[CTRL_EN];
  assign clock_polarity_bit = s.ctrl[CTRL_CKP];
  assign mode = s.ctrl[3:0];
  assign master = ssp_is_master(mode);
  assign slave = ssp_is_slave(mode);
  assign i2c = ssp_is_i2c(mode);
  assign wr_go = s.aw_v && s.w_v && !s.bvalid;
  assign rd_go = arvalid && s.arready;

  ssp_baud u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(en && master && s.busy),
    .sel(mode[1:0]),
    .tick(tick)
  );

  always_comb begin
    next_s = s;
    done_evt = 1'b0;
    ovf_evt = 1'b0;
    rx_byte = {s.sh[6:0], pin_in[2]};
    sck_edge = slave ? (pin_in[0] != s.sck_q) : tick;
    next_s.sck_q = pin_in[0];

    // Bus channel capture
    if (awvalid && s.awready) begin
      next_s.aw_v = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_v = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    // Register writes
    if (wr_go) begin
      next_s.aw_v = 1'b0;
      next_s.w_v = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_ok(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.wstrb0) begin
        unique case (s.awaddr)
          ADDR_CTRL: next_s.ctrl = s.wdata[7:0];
          ADDR_BUF: begin
            if (en && !s.busy) begin
              next_s.txb = s.wdata[7:0];
              next_s.sh = s.wdata[7:0];
              if (master) begin
                next_s.busy = 1'b1;
                next_s.bitcnt = 4'h0;
                next_s.phase = PH_LEAD;
              end
            end
          end
          ADDR_ISR: next_s.isr = s.isr & ~s.wdata[1:0];
          ADDR_IMR: next_s.imr = s.wdata[1:0];
          default: next_s.bresp = next_s.bresp;
        endcase
      end
    end

    // Register reads
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = 32'h0000_0000;
      unique case (araddr)
        ADDR_CTRL: next_s.rdata[7:0] = s.ctrl;
        ADDR_BUF: begin
          next_s.rdata[7:0] = s.rxb;
          next_s.bf = 1'b0;
        end
        ADDR_STAT: begin
          next_s.rdata[STAT_BF] = s.bf;
          next_s.rdata[STAT_BUSY] = s.busy;
        end
        ADDR_ISR: next_s.rdata[1:0] = s.isr;
        ADDR_IMR: next_s.rdata[1:0] = s.imr;
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Shift engine
    if (!en) begin
      next_s.bf = 1'b0;
      next_s.busy = 1'b0;
      next_s.bitcnt = 4'h0;
      next_s.phase = PH_LEAD;
    end else if (slave && mode == MODE_SL_SS && ss_n) begin
      next_s.busy = 1'b0;
      next_s.bitcnt = 4'h0;
      next_s.phase = PH_LEAD;
    end else if ((slave || (master && s.busy)) && sck_edge) begin
      unique case (s.phase)
        PH_LEAD: begin
          next_s.serial_out_pin = s.sh[7];
          next_s.phase = PH_TRAIL;
          next_s.busy = 1'b1;
          next_s.sck = ~clock_polarity_bit;
        end
        PH_TRAIL: begin
          next_s.sh = rx_byte;
          next_s.bitcnt = s.bitcnt + 4'h1;
          next_s.phase = PH_LEAD;
          next_s.sck = clock_polarity_bit;
          if (s.bitcnt == LAST_BIT) begin
            done_evt = 1'b1;
            next_s.busy = 1'b0;
            next_s.bitcnt = 4'h0;
            next_s.sh = s.txb;
            if (s.bf && slave) begin
              ovf_evt = 1'b1;
            end else begin
              next_s.rxb = rx_byte;
              next_s.bf = 1'b1;
            end
          end
        end
      endcase
    end
    if (!next_s.busy) begin
      next_s.sck = clock_polarity_bit;
    end

    // Sticky events win over software clears
    if (ovf_evt) begin
      next_s.ctrl[CTRL_OV] = 1'b1;
    end
    next_s.isr[IRQ_OV] = next_s.isr[IRQ_OV] | ovf_evt;
    next_s.isr[IRQ_DONE] = next_s.isr[IRQ_DONE] | done_evt;
    next_s.irq = |(next_s.isr & next_s.imr);

    // Pin routing
    next_s.pins = gpio;
    if (en && master) begin
      next_s.pins.o = {1'b0, next_s.serial_out_pin, next_s.sck};
      next_s.pins.oe = 3'b011;
    end else if (en && slave) begin
      next_s.pins.o = {1'b0, next_s.serial_out_pin, 1'b0};
      next_s.pins.oe = {1'b0, !(mode == MODE_SL_SS && ss_n), 1'b0};
    end else if (en && i2c) begin
      next_s.pins.o = {gpio.o[2], 2'b00};
      next_s.pins.oe = {gpio.oe[2], 1'b0, !clock_polarity_bit};
    end

    // Ready only while the channel holding slot is free
    next_s.awready = !next_s.aw_v;
    next_s.wready = !next_s.w_v;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign pins = s.pins;
  assign irq = s.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ov_set;
    (done_evt && s.bf && slave && en) |=> s.ctrl[CTRL_OV] && s.isr[IRQ_OV];
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("overflow flag not set");

  property p_ov_keep;
    ovf_evt |=> (s.rxb == $past(s.rxb)) && s.bf;
  endproperty
  a_ov_keep: assert property (p_ov_keep) else $error("buffer changed on overflow");

  property p_ov_slave;
    ovf_evt |-> slave && en;
  endproperty
  a_ov_slave: assert property (p_ov_slave) else $error("overflow outside slave mode");

  property p_master_no_ov;
    (master && !s.ctrl[CTRL_OV] && !wr_go) |=> !s.ctrl[CTRL_OV];
  endproperty
  a_master_no_ov: assert property (p_master_no_ov) else $error("master set overflow");

  property p_spi_pins;
    (en && master) |=> (s.pins.oe == 3'b011) && (s.pins.o[0] == s.sck);
  endproperty
  a_spi_pins: assert property (p_spi_pins) else $error("spi pins not routed");

  property p_gpio;
    !en |=> s.pins == $past(gpio);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pins not returned to gpio");

  property p_i2c_pins;
    (en && i2c && !clock_polarity_bit) ##1 (en && i2c && !clock_polarity_bit) |-> s.pins.oe[0] && !s.pins.o[0];
  endproperty
  a_i2c_pins: assert property (p_i2c_pins) else $error("scl not held low");

  property p_idle_hi;
    (en && master && clock_polarity_bit && !s.busy) |=> s.pins.o[0];
  endproperty
  a_idle_hi: assert property (p_idle_hi) else $error("clock not idle high");

  property p_idle_lo;
    (en && master && !clock_polarity_bit && !s.busy) |=> !s.pins.o[0];
  endproperty
  a_idle_lo: assert property (p_idle_lo) else $error("clock not idle low");

  property p_bf;
    (done_evt && !ovf_evt) |=> s.bf;
  endproperty
  a_bf: assert property (p_bf) else $error("buffer full flag not set");

  property p_bf_clear;
    !en |=> !s.bf;
  endproperty
  a_bf_clear: assert property (p_bf_clear) else $error("buffer full while disabled");

  property p_stretch_release;
    (en && i2c && clock_polarity_bit) |=> !s.pins.oe[0];
  endproperty
  a_stretch_release: assert property (p_stretch_release) else $error("scl not released");

endmodule // ssp_top

/* tb/ssp_peer.sv */
`timescale 1ns/1ps
module ssp_peer import ssp_pkg::*; (
  // Clock and polarity
  input wire logic aclk,
  input wire logic clock_polarity_bit,
  // Pins
  input wire ssp_pins_t pins,
  output logic [2:0] pin_in
);
  logic [2:0] drv = 3'h0;
  logic act = 1'b0;
  logic ld = 1'b0;
  logic last = 1'b0;
  logic [7:0] reply = 8'h00;
  logic [7:0] seen = 8'h00;
  logic [31:0] cnt = 32'h0;
  logic [31:0] half_seen = 32'h0;
  // Port wins where it drives; released lines keep changing
  assign pin_in = (pins.oe & pins.o) | (~pins.oe & drv);
  always @(posedge aclk) begin
    last <= pin_in[0];
    cnt <= cnt + 32'h1;
    drv[1] <= ~drv[1];
    if (ld) begin
      ld <= 1'b0;
      drv[2] <= reply[7];
      reply <= {reply[6:0], 1'b0};
    end else if (!act) begin
      drv[0] <= clock_polarity_bit;
      drv[2] <= ~drv[2];
    end else if (pins.oe[0] && pin_in[0] != last) begin
      cnt <= 32'h1;
      half_seen <= cnt;
      if (pin_in[0] == clock_polarity_bit) begin
        seen <= {seen[6:0], pin_in[1]};
        drv[2] <= reply[7];
        reply <= {reply[6:0], 1'b0};
      end
    end
  end
  task automatic arm(input logic [7:0] r);
    reply <= r;
    ld <= 1'b1;
    act <= 1'b1;
  endtask
  task automatic idle();
    act <= 1'b0;
  endtask
  // Master side, half period of four cycles
  task automatic send(input logic [7:0] b);
    act <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge aclk);
      drv[0] <= ~clock_polarity_bit;
      drv[2] <= b[i];
      repeat (4) @(posedge aclk);
      drv[0] <= clock_polarity_bit;
      repeat (3) @(posedge aclk);
    end
  endtask
endmodule // ssp_peer

/* tb/tb.sv */
`timescale 1ns/1ps
module tb import ssp_pkg::*; ();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic clock_polarity_bit = 1'b0;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] cv;
  logic [5:0] hv;
  logic [2:0] pin_in;
  ssp_pins_t pins;
  ssp_pins_t gpio = '{o: 3'h5, oe: 3'h3};
  int mismatches = 0;
  int samples_checked = 0;

  always #10 aclk = ~aclk;

  ssp_top ssp_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .gpio(gpio), .pin_in(pin_in), .ss_n(1'b1), .pins(pins), .irq(irq));
  ssp_peer ssp_peer_inst (.aclk(aclk), .clock_polarity_bit(clock_polarity_bit), .pins(pins), .pin_in(pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Mismatches %0d, checks %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    check({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(d, e);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic [7:0] rx);
    ssp_peer_inst.arm(rx);
    wr(ADDR_BUF, {24'h0, tx});
    d = 32'h2;
    while (d[STAT_BUSY] === 1'b1) rd(ADDR_STAT);
    ssp_peer_inst.idle();
    check({24'h0, ssp_peer_inst.seen}, {24'h0, tx});
  endtask

  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(ADDR_CTRL, {24'h0, CTRL_RST});
    rd(8'h14);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check({26'h0, pins}, {26'h0, gpio});
    for (int m = 0; m < 3; m++) begin
      cv = {2'b00, 1'b1, m[0], m[3:0]};
      hv = (m == 0) ? HALF_4 : (m == 1) ? HALF_16 : HALF_64;
      clock_polarity_bit <= m[0];
      wr(ADDR_CTRL, {24'h0, cv});
      repeat (3) @(posedge aclk);
      check({31'h0, pins.o[0]}, {31'h0, cv[CTRL_CKP]});
      xfer(8'ha5 ^ m[7:0], 8'h3c);
      check(ssp_peer_inst.half_seen, {26'h0, hv});
      xfer(8'h5a, 8'hc3);
      check({31'h0, pins.o[0]}, {31'h0, cv[CTRL_CKP]});
      rchk(ADDR_CTRL, {24'h0, cv});
      rchk(ADDR_STAT, 32'h1);
      rchk(ADDR_BUF, 32'hc3);
      rchk(ADDR_STAT, 32'h0);
    end
    clock_polarity_bit <= 1'b0;
    wr(ADDR_ISR, 32'h3);
    wr(ADDR_IMR, 32'h1 << IRQ_OV);
    wr(ADDR_CTRL, 32'h25);
    ssp_peer_inst.send(8'h81);
    repeat (4) @(posedge aclk);
    rchk(ADDR_BUF, 32'h81);
    ssp_peer_inst.send(8'h42);
    ssp_peer_inst.send(8'h99);
    ssp_peer_inst.idle();
    repeat (4) @(posedge aclk);
    rchk(ADDR_CTRL, 32'h65);
    check({31'h0, irq}, 32'h1);
    rchk(ADDR_BUF, 32'h42);
    wr(ADDR_ISR, 32'h1 << IRQ_OV);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    rchk(ADDR_CTRL, 32'h65);
    wr(ADDR_CTRL, 32'h26);
    repeat (3) @(posedge aclk);
    check({30'h0, pins.oe[0], pins.o[0]}, 32'h2);
    wr(ADDR_CTRL, 32'h36);
    repeat (3) @(posedge aclk);
    check({30'h0, pins.oe[0], pins.o[0]}, 32'h0);
    wr(ADDR_CTRL, 32'h00);
    repeat (3) @(posedge aclk);
    check({26'h0, pins}, {26'h0, gpio});
    summarize();
  end
endmodule // tb
